// >>> include/pcsf_pkg.sv
// Constants shared by the fabric-side PCS stages: register map, fields, resets, latencies.
// Assumes a single 50 MHz clock and an APB register bus with 32-bit data.
package pcsf_pkg;

   // ------------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------------
   localparam int PCSF_ADDR_W = 12;
   localparam int PCSF_DATA_W = 32;
   localparam logic [11:0] PCSF_OFF_CTRL = 12'h000;
   localparam logic [11:0] PCSF_OFF_PATTERN = 12'h004;
   localparam logic [11:0] PCSF_OFF_PAD = 12'h008;
   localparam logic [11:0] PCSF_OFF_STATUS = 12'h00c;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int PCSF_CTRL_W = 14;
   localparam int PCSF_C_TX_REG = 0;
   localparam int PCSF_C_RX_REG = 1;
   localparam int PCSF_C_ORD_EN = 2;
   localparam int PCSF_C_AUTO = 3;
   localparam int PCSF_C_TWO_SYM = 4;
   localparam int PCSF_C_SYM10 = 5;
   localparam int PCSF_C_TXF_EN = 8;
   localparam int PCSF_C_TXE_EN = 9;
   localparam int PCSF_C_RXF_EN = 10;
   localparam int PCSF_C_RXE_EN = 11;
   localparam int PCSF_C_RME_EN = 12;
   localparam int PCSF_C_RMF_EN = 13;
   localparam logic [13:0] PCSF_CTRL_RST = 14'h0020;

   // ------------------------------------------------------------------
   // Symbol layout and pattern defaults
   // ------------------------------------------------------------------
   localparam int PCSF_SYM_W = 10;
   localparam int PCSF_NSYM = 4;
   localparam int PCSF_BYTE_W = 8;
   localparam logic [9:0] PCSF_PATTERN_RST = 10'h0bc;
   localparam logic [9:0] PCSF_PAD_RST = 10'h09c;

   // ------------------------------------------------------------------
   // Phase compensation latencies in FIFO mode
   // ------------------------------------------------------------------
   localparam int PCSF_TX_LAT = 3;
   localparam int PCSF_RX_LAT = 2;

   // ------------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------------
   localparam int PCSF_S_PEND = 0;
   localparam int PCSF_S_TXF = 1;
   localparam int PCSF_S_TXE = 2;
   localparam int PCSF_S_RXF = 3;
   localparam int PCSF_S_RXE = 4;
   localparam int PCSF_S_RMF = 5;
   localparam int PCSF_S_RME = 6;
   localparam int PCSF_S_SHIFT = 8;
   localparam int PCSF_S_COUNT = 16;
   localparam int PCSF_CNT_W = 8;

endpackage

// >>> src/pcsf_pcfifo.sv
// Phase compensation stage: a fixed-latency pipeline in FIFO mode, one register in register mode.
// Assumes both sides share i_clk; the stage absorbs alignment by a fixed depth.
`timescale 1ns/1ns
module pcsf_pcfifo #(
   parameter int W = 40,
   parameter int LAT = 3
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_reg_mode,
   input wire logic i_full_en,
   input wire logic i_empty_en,
   input wire logic [W-1:0] i_data,
   input wire logic i_valid,
   output logic [W-1:0] o_data,
   output logic o_valid,
   output logic o_full,
   output logic o_empty
);

   initial begin
      if (LAT < 2 || LAT > 8) begin
         $error("pcsf_pcfifo: LAT must lie in 2..8");
      end
   end

   logic [W-1:0] stage_d [LAT-1];
   logic [LAT-2:0] stage_v;
   wire all_full = (&stage_v) & i_valid;
   wire all_empty = ~(|stage_v);
   wire [W-1:0] next_data = i_reg_mode ? i_data : stage_d[LAT-2];
   wire next_valid = i_reg_mode ? i_valid : stage_v[LAT-2];

   // Shifting every cycle keeps the latency fixed, which is what deterministic protocols need.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         stage_v <= '0;
         o_valid <= 1'b0;
         o_data <= '0;
         o_full <= 1'b0;
         o_empty <= 1'b0;
      end else begin
         stage_v <= (LAT-1)'({stage_v, i_valid});
         o_valid <= next_valid;
         o_data <= next_data;
         o_full <= i_full_en & ~i_reg_mode & all_full;
         o_empty <= i_empty_en & ~i_reg_mode & all_empty;
      end
   end

   always_ff @(posedge i_clk) begin
      stage_d[0] <= i_data;
      for (int i = 1; i < LAT - 1; i++) begin
         stage_d[i] <= stage_d[i-1];
      end
   end

endmodule

// >>> src/pcsf_top.sv
// Fabric-side PCS stages: TX and RX phase compensation, RX byte ordering, FIFO status flags.
// Assumes one clock for fabric and PCS sides, an APB master, and a word aligner on i_clk.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module pcsf_top
   import pcsf_pkg::*;
#(
   parameter int SYM_W = PCSF_SYM_W,
   parameter int NSYM = PCSF_NSYM,
   parameter int TX_LAT = PCSF_TX_LAT,
   parameter int RX_LAT = PCSF_RX_LAT
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [PCSF_ADDR_W-1:0] i_paddr,
   input wire logic [PCSF_DATA_W-1:0] i_pwdata,
   output logic [PCSF_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [SYM_W*NSYM-1:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic [SYM_W*NSYM-1:0] o_tx_data,
   output logic o_tx_valid,
   input wire logic [SYM_W*NSYM-1:0] i_rx_data,
   input wire logic i_rx_valid,
   input wire logic i_align_done,
   input wire logic i_order_req,
   output logic [SYM_W*NSYM-1:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_byte_ordered,
   input wire logic i_rm_full,
   input wire logic i_rm_empty,
   output logic o_tx_pc_full,
   output logic o_tx_pc_empty,
   output logic o_rx_pc_full,
   output logic o_rx_pc_empty,
   output logic o_rm_full,
   output logic o_rm_empty
);

   localparam int DW = SYM_W * NSYM;
   localparam int PW = $clog2(NSYM);

   initial begin
      if (SYM_W < PCSF_BYTE_W || SYM_W > PCSF_SYM_W || NSYM < 2 || (NSYM & (NSYM - 1)) != 0) begin
         $error("pcsf_top: SYM_W must be 8..10 and NSYM a power of two, at least 2");
      end
   end

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------
   function automatic logic sym_eq(input logic [SYM_W-1:0] sym, input logic [9:0] pat,
                                   input logic wide);
      logic full_eq;
      logic byte_eq;
      full_eq = (sym == pat[SYM_W-1:0]);
      byte_eq = (sym[PCSF_BYTE_W-1:0] == pat[PCSF_BYTE_W-1:0]);
      return wide ? full_eq : byte_eq;
   endfunction

   // Lowest symbol position holding the pattern; bit PW is the found flag.
   function automatic logic [PW:0] find_pat(input logic [DW-1:0] word, input logic [9:0] pat,
                                            input logic wide, input logic two);
      logic [PW:0] res;
      logic hit;
      res = '0;
      for (int p = NSYM - 1; p >= 0; p--) begin
         hit = sym_eq(word[p*SYM_W +: SYM_W], pat, wide);
         if (two) begin
            hit = hit && (p < NSYM - 1) && sym_eq(word[(p+1)*SYM_W +: SYM_W], pat, wide);
         end
         if (hit) begin
            res = {1'b1, PW'(p)};
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   logic [PCSF_CTRL_W-1:0] ctrl;
   logic [9:0] pattern;
   logic [9:0] pad;
   logic [PCSF_DATA_W-1:0] status_word;

   wire setup = i_psel & ~i_penable;
   wire wr_en = i_psel & i_penable & o_pready & i_pwrite;
   wire hit_ctrl = (i_paddr == PCSF_OFF_CTRL);
   wire hit_pat = (i_paddr == PCSF_OFF_PATTERN);
   wire hit_pad = (i_paddr == PCSF_OFF_PAD);
   wire hit_stat = (i_paddr == PCSF_OFF_STATUS);
   wire mapped = hit_ctrl | hit_pat | hit_pad | hit_stat;
   wire [PCSF_DATA_W-1:0] rd_mux =
      hit_ctrl ? PCSF_DATA_W'(ctrl) :
      hit_pat ? PCSF_DATA_W'(pattern) :
      hit_pad ? PCSF_DATA_W'(pad) :
      hit_stat ? status_word : '0;

   // The answer is prepared in the setup cycle so that ready and data come straight from flops.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= setup;
         o_pslverr <= setup & ~mapped;
         o_prdata <= (setup & ~i_pwrite) ? rd_mux : '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ctrl <= PCSF_CTRL_RST;
         pattern <= PCSF_PATTERN_RST;
         pad <= PCSF_PAD_RST;
      end else if (wr_en) begin
         if (hit_ctrl) begin
            ctrl <= i_pwdata[PCSF_CTRL_W-1:0];
         end
         if (hit_pat) begin
            pattern <= i_pwdata[9:0];
         end
         if (hit_pad) begin
            pad <= i_pwdata[9:0];
         end
      end
   end

   wire ord_en = ctrl[PCSF_C_ORD_EN];
   wire auto_mode = ctrl[PCSF_C_AUTO];
   wire sym10 = ctrl[PCSF_C_SYM10];
   wire two_sym = ctrl[PCSF_C_TWO_SYM];

   // ------------------------------------------------------------------
   // Transmit phase compensation
   // ------------------------------------------------------------------
   pcsf_pcfifo #(.W(DW), .LAT(TX_LAT)) u_tx_pc (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_reg_mode(ctrl[PCSF_C_TX_REG]),
      .i_full_en(ctrl[PCSF_C_TXF_EN]),
      .i_empty_en(ctrl[PCSF_C_TXE_EN]),
      .i_data(i_tx_data),
      .i_valid(i_tx_valid),
      .o_data(o_tx_data),
      .o_valid(o_tx_valid),
      .o_full(o_tx_pc_full),
      .o_empty(o_tx_pc_empty)
   );

   // ------------------------------------------------------------------
   // Receive byte ordering
   // ------------------------------------------------------------------
   logic req_q;
   logic align_q;
   logic pending;
   logic [PW-1:0] shift;
   logic [DW-1:0] prev;
   logic [DW-1:0] ord_data;
   logic ord_valid;
   logic [PCSF_CNT_W-1:0] op_count;

   wire req_rise = i_order_req & ~req_q;
   wire align_rise = i_align_done & ~align_q;
   wire trigger = ord_en & (auto_mode ? align_rise : req_rise);
   wire [PW:0] found = find_pat(i_rx_data, pattern, sym10, two_sym & (NSYM > 1));
   wire op = pending & ord_en & i_rx_valid & found[PW];
   wire [PW-1:0] use_shift = op ? found[PW-1:0] : (ord_en ? shift : '0);
   wire [SYM_W-1:0] pad_sym = sym10 ? pad[SYM_W-1:0] :
                                      SYM_W'(pad[PCSF_BYTE_W-1:0]);
   wire [DW-1:0] pad_word = {NSYM{pad_sym}};
   wire [2*DW-1:0] joined = {i_rx_data, op ? pad_word : prev};
   wire [2*DW-1:0] shifted = joined >> (int'(use_shift) * SYM_W);
   wire [DW-1:0] window = shifted[DW-1:0];

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         req_q <= 1'b0;
         align_q <= 1'b0;
         pending <= 1'b0;
         shift <= '0;
         op_count <= '0;
      end else begin
         req_q <= i_order_req;
         align_q <= i_align_done;
         pending <= trigger | (pending & ~op & ord_en);
         if (op) begin
            shift <= found[PW-1:0];
            op_count <= op_count + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         prev <= '0;
         ord_data <= '0;
         ord_valid <= 1'b0;
         o_byte_ordered <= 1'b0;
      end else begin
         if (i_rx_valid) begin
            prev <= i_rx_data;
            ord_data <= window;
         end
         ord_valid <= i_rx_valid;
         o_byte_ordered <= op;
      end
   end

   // ------------------------------------------------------------------
   // Receive phase compensation and rate match flags
   // ------------------------------------------------------------------
   pcsf_pcfifo #(.W(DW), .LAT(RX_LAT)) u_rx_pc (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_reg_mode(ctrl[PCSF_C_RX_REG]),
      .i_full_en(ctrl[PCSF_C_RXF_EN]),
      .i_empty_en(ctrl[PCSF_C_RXE_EN]),
      .i_data(ord_data),
      .i_valid(ord_valid),
      .o_data(o_rx_data),
      .o_valid(o_rx_valid),
      .o_full(o_rx_pc_full),
      .o_empty(o_rx_pc_empty)
   );

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_rm_full <= 1'b0;
         o_rm_empty <= 1'b0;
      end else begin
         o_rm_full <= ctrl[PCSF_C_RMF_EN] & i_rm_full;
         o_rm_empty <= ctrl[PCSF_C_RME_EN] & i_rm_empty;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[PCSF_S_PEND] = pending;
      status_word[PCSF_S_TXF] = o_tx_pc_full;
      status_word[PCSF_S_TXE] = o_tx_pc_empty;
      status_word[PCSF_S_RXF] = o_rx_pc_full;
      status_word[PCSF_S_RXE] = o_rx_pc_empty;
      status_word[PCSF_S_RMF] = o_rm_full;
      status_word[PCSF_S_RME] = o_rm_empty;
      status_word[PCSF_S_SHIFT +: PW] = shift;
      status_word[PCSF_S_COUNT +: PCSF_CNT_W] = op_count;
   end

endmodule

// >>> tb/pcsf_top_checker.sv
// Port-level timing checks for pcsf_top.
// Assumes it is bound into pcsf_top; one clock, reset low-active.
`timescale 1ns/1ns
module pcsf_top_checker
   import pcsf_pkg::*;
#(
   parameter int SYM_W = PCSF_SYM_W,
   parameter int NSYM = PCSF_NSYM
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [PCSF_ADDR_W-1:0] i_paddr,
   input wire logic [PCSF_DATA_W-1:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [SYM_W*NSYM-1:0] i_tx_data,
   input wire logic i_tx_valid,
   input wire logic [SYM_W*NSYM-1:0] o_tx_data,
   input wire logic o_tx_valid,
   input wire logic i_rx_valid,
   input wire logic o_rx_valid,
   input wire logic o_byte_ordered,
   input wire logic i_rm_full,
   input wire logic o_rm_full
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_ack; i_psel && !i_penable |=> o_pready ##1 !o_pready; endproperty
   a_ack: assert property (p_ack) else $error("ready timing wrong");
   property p_err; o_pready |-> i_penable && o_pslverr == (i_paddr > 12'h00c); endproperty
   a_err: assert property (p_err) else $error("slave error wrong");
   property p_rdz; !o_pready |-> o_prdata == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("read data not idle");
   property p_tx; o_tx_valid |-> $past(i_tx_valid, 3) && o_tx_data == $past(i_tx_data, 3)
      || $past(i_tx_valid) && o_tx_data == $past(i_tx_data); endproperty
   a_tx: assert property (p_tx) else $error("tx word late or wrong");
   property p_rx; o_rx_valid |-> $past(i_rx_valid, 3) || $past(i_rx_valid, 2); endproperty
   a_rx: assert property (p_rx) else $error("rx word late");
   property p_bo1; o_byte_ordered |=> !o_byte_ordered; endproperty
   a_bo1: assert property (p_bo1) else $error("ordered flag too long");
   property p_bo2; o_byte_ordered |-> $past(i_rx_valid) ##[1:2] o_rx_valid; endproperty
   a_bo2: assert property (p_bo2) else $error("ordered flag without word");
   property p_rm; o_rm_full |-> $past(i_rm_full); endproperty
   a_rm: assert property (p_rm) else $error("rate match full wrong");
endmodule

// >>> tb/pcsf_fabric_model.sv
// Fabric logic partner: sources transmit words and raises ordering requests.
// Assumes the bench sets the source mode and calls request just after an edge.
`timescale 1ns/1ns
module pcsf_fabric_model (
   input wire logic i_clk,
   input wire logic [1:0] i_mode,
   output logic [39:0] o_tx_data,
   output logic o_tx_valid,
   output logic o_order_req
);
   int seed = 32'h2c73f575;
   logic [63:0] rnd;
   initial begin
      o_tx_data = 40'h0;
      o_tx_valid = 1'b0;
      o_order_req = 1'b0;
   end
   // Data changes every cycle, so an idle word never repeats the last valid one.
   always @(posedge i_clk) begin
      rnd = {$random(seed), $random(seed)};
      o_tx_data <= rnd[39:0];
      o_tx_valid <= i_mode[1] || (i_mode[0] && rnd[40]);
   end
   task request(input int hold);
      o_order_req <= 1'b1;
      repeat (hold) @(posedge i_clk);
      o_order_req <= 1'b0;
      @(posedge i_clk);
   endtask
endmodule

// >>> tb/pcsf_top_bench.sv
// Self-checking bench for pcsf_top with a queue model of both datapaths.
// Assumes the fabric model drives transmit words and ordering requests.
`timescale 1ns/1ns
module pcsf_top_bench
   import pcsf_pkg::*;
;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rxv = 1'b0;
   logic al = 1'b0, rmf = 1'b0, rme = 1'b0, pready, pslverr, txv, otxv, orxv, bo, req, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [39:0] txd, otxd, rxd = 40'h0, orxd, prev, w;
   logic [1:0] mode = 2'h0;
   wire [5:0] fl;
   logic [13:0] ctrl = PCSF_CTRL_RST, ctrl_q = 14'h0;
   logic [9:0] pat = PCSF_PATTERN_RST, pad = PCSF_PAD_RST;
   logic [13:0] cfg [5] = '{14'h0024, 14'h0004, 14'h0034, 14'h0026, 14'h002c};
   logic [11:0] ad [4] = '{PCSF_OFF_CTRL, PCSF_OFF_PATTERN, PCSF_OFF_PAD, 12'h010};
   logic [31:0] rv [4] = '{32'(PCSF_CTRL_RST), 32'(PCSF_PATTERN_RST), 32'(PCSF_PAD_RST), 32'h0};
   logic [39:0] wd [3] = '{{10'h0bc, 10'h0bc, 10'h3bc, 10'h155},
      {10'h0bc, 10'h155, 10'h155, 10'h155}, {10'h155, 10'h155, 10'h155, 10'h0bc}};
   logic [39:0] q_w [$], t_w [$];
   int q_c [$], t_c [$];
   int seed = 32'h2c73f575;
   int fail_count = 0, n_tests = 0, cyc = 0, s, p;
   logic pend, rq, aq, ebo;
   logic [1:0] erm;
   always #10 clk = ~clk;
   pcsf_top u_pcsf_top (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_data(otxd),
      .o_tx_valid(otxv), .i_rx_data(rxd), .i_rx_valid(rxv), .i_align_done(al),
      .i_order_req(req), .o_rx_data(orxd), .o_rx_valid(orxv), .o_byte_ordered(bo),
      .i_rm_full(rmf), .i_rm_empty(rme), .o_tx_pc_full(fl[0]), .o_tx_pc_empty(fl[1]),
      .o_rx_pc_full(fl[2]), .o_rx_pc_empty(fl[3]), .o_rm_full(fl[4]), .o_rm_empty(fl[5]));
   pcsf_fabric_model u_pcsf_fabric_model (.i_clk(clk), .i_mode(mode), .o_tx_data(txd),
      .o_tx_valid(txv), .o_order_req(req));
   task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_tests++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         fail_count++;
      end
   endtask
   task test_done;
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) begin
         chk("apb_wait", 1, 0);
         test_done;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (wr && a == PCSF_OFF_CTRL) ctrl <= d[13:0];
      // One idle edge keeps the next setup from reassigning psel in this time step.
      @(posedge clk);
   endtask
   function automatic logic mt(input logic [9:0] y);
      return ctrl[5] ? y == pat : y[7:0] == pat[7:0];
   endfunction
   // Background symbols keep bit 7 low and bit 8 high, so they never match.
   function automatic logic [39:0] bgw();
      logic [31:0] r;
      r = $random(seed);
      return {3'h2, r[6:0], 3'h2, r[13:7], 3'h2, r[20:14], 3'h2, r[27:21]};
   endfunction
   task send(input logic [39:0] x);
      rxd <= x;
      rxv <= 1'b1;
      @(posedge clk);
   endtask
   task round(input int r);
      fork
         u_pcsf_fabric_model.request(6);
      join_none
      al <= 1'b1;
      send(bgw());
      send(bgw());
      for (int i = 0; i < 3; i++) begin
         send(wd[(r + i) % 3]);
         send(bgw());
      end
      al <= 1'b0;
      repeat (3) send(bgw());
   endtask
   always @(posedge clk) begin
      logic [31:0] rn;
      if (!rstn) begin
         pend = 1'b0;
         rq = 1'b0;
         aq = 1'b0;
         ebo = 1'b0;
         erm = 2'h0;
         s = 0;
         prev = 40'h0;
      end else begin
         cyc++;
         chk("ordered", ebo, bo);
         chk("rm_flags", erm, fl[5:4]);
         chk("pc_flags", fl[3:0] & ~ctrl_q[11:8], 0);
         ebo = 1'b0;
         erm = {rme & ctrl[12], rmf & ctrl[13]};
         ctrl_q = ctrl;
         rn = $random(seed);
         rmf <= rn[0];
         rme <= rn[1];
         if (txv) begin
            t_w.push_back(txd);
            t_c.push_back(cyc);
         end
         if (otxv) begin
            chk("tx_data", t_w.pop_front(), otxd);
            chk("tx_lat", ctrl[0] ? 1 : PCSF_TX_LAT, cyc - t_c.pop_front());
         end
         if (rxv) begin
            p = 4;
            for (int k = 3; k >= 0; k--)
               if (mt(rxd[k*10 +: 10]) && (!ctrl[4] || k < 3 && mt(rxd[k*10+10 +: 10]))) p = k;
            if (pend && ctrl[2] && p < 4) begin
               w = 40'({rxd, {4{ctrl[5] ? pad : {2'h0, pad[7:0]}}}} >> (p * 10));
               s = p;
               ebo = 1'b1;
               pend = 1'b0;
            end else
               w = 40'({rxd, prev} >> (s * 10));
            prev = rxd;
            q_w.push_back(w);
            q_c.push_back(cyc);
         end
         if (!ctrl[2]) begin
            pend = 1'b0;
            s = 0;
         end else if (ctrl[3] ? al && !aq : req && !rq) pend = 1'b1;
         rq = req;
         aq = al;
         if (orxv) begin
            chk("rx_data", q_w.pop_front(), orxd);
            chk("rx_lat", ctrl[1] ? 2 : 1 + PCSF_RX_LAT, cyc - q_c.pop_front());
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      chk("timeout", 1, 0);
      test_done;
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ad[i], 32'h0);
         chk("reg_rd", rv[i], rd);
         chk("reg_err", i == 3, err);
      end
      apb(1'b1, PCSF_OFF_CTRL, 32'h3f20);
      mode <= 2'h1;
      repeat (40) @(posedge clk);
      mode <= 2'h2;
      repeat (6) @(posedge clk);
      chk("tx_full", 1, fl[0]);
      mode <= 2'h0;
      repeat (6) @(posedge clk);
      chk("tx_empty", 1, fl[1]);
      chk("rx_empty", 1, fl[3]);
      apb(1'b1, PCSF_OFF_CTRL, 32'h3);
      mode <= 2'h1;
      repeat (40) @(posedge clk);
      mode <= 2'h0;
      repeat (4) @(posedge clk);
      for (int c = 0; c < 5; c++) begin
         apb(1'b1, PCSF_OFF_CTRL, {18'h0, cfg[c]});
         for (int r = 0; r < 3; r++) round(r);
         rxv <= 1'b0;
         repeat (6) @(posedge clk);
      end
      test_done;
   end
endmodule
bind pcsf_top pcsf_top_checker #(.SYM_W(SYM_W), .NSYM(NSYM)) u_pcsf_top_checker (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
   .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_data(o_tx_data),
   .o_tx_valid(o_tx_valid), .i_rx_valid(i_rx_valid), .o_rx_valid(o_rx_valid),
   .o_byte_ordered(o_byte_ordered), .i_rm_full(i_rm_full), .o_rm_full(o_rm_full));
